/* File: hw/pic_pkg.sv */
// package: constants, types and vector table of the interrupt controller
package pic_pkg;
   // source count and latch layout
   localparam int NUM_SRC = 24; // sources besides reset
   localparam int FIRST_LATCH = 2; // lowest index with a latch
   localparam logic [4:0] IDX_TRAP = 5'h02; // address trap latch
   localparam logic [4:0] IDX_WDT = 5'h03; // watchdog latch
   localparam logic [4:0] IDX_MASKABLE = 5'h04; // first maskable latch
   localparam logic [4:0] IDX_SPLIT = 5'h10; // second vector block
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_EN_HIGH = 8'h2c; // enables 23..16
   localparam logic [7:0] IDX_IL_HIGH = 8'h2e; // latches 23..16
   localparam logic [7:0] IDX_CTRL = 8'h30; // action selects, pin enable
   localparam logic [7:0] IDX_STAT = 8'h31; // busy flag, pending flag, winner index
   localparam logic [7:0] IDX_EN_LOW = 8'h3a; // enables 7..4, master
   localparam logic [7:0] IDX_EN_MID = 8'h3b; // enables 15..8
   localparam logic [7:0] IDX_IL_LOW = 8'h3c; // latches 7..2
   localparam logic [7:0] IDX_IL_MID = 8'h3d; // latches 15..8
   // field positions and reset values
   localparam int IMF_BIT = 0; // master enable in low enable byte
   localparam int TRAP_SEL_BIT = 0; // 1: trap gives reset
   localparam int WDT_SEL_BIT = 1; // 1: watchdog gives reset
   localparam int PIN0_EN_BIT = 2; // external source 0 pin enable
   localparam logic [2:0] CTRL_RESET = 3'h3; // both select reset
   localparam logic [19:0] EF_RESET = 20'h00000; // all disabled
   localparam logic IMF_RESET = 1'b0; // master enable off
   // acceptance timing
   localparam int MCYC_CLKS = 1; // core clocks per machine cycle
   localparam int ACCEPT_MCYC = 8; // machine cycles of acceptance
   localparam logic [3:0] ACCEPT_CLKS = 4'(ACCEPT_MCYC * MCYC_CLKS);
   localparam logic [3:0] LAST_PUSH = 4'h3; // pushes at steps 1..3
   // vectors
   localparam logic [15:0] VEC_SOFT = 16'hfffc; // software, illegal op
   localparam logic [15:0] VEC_TRAP = 16'hfffa; // address trap
   localparam logic [15:0] VEC_WDT = 16'hfff8; // watchdog
   localparam logic [15:0] VEC_LOW_BASE = 16'hfff6; // latch 4
   localparam logic [15:0] VEC_HIGH_BASE = 16'hffbe; // latch 16
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PUSH = 3'b010,
      ST_LOAD = 3'b100
   } pic_state_type;
   // priority winner
   typedef struct packed {
      logic valid; // some request is eligible
      logic [4:0] idx; // its latch index
   } pic_win_type;
   // vector of a latch index; index 0 stands for the shared soft vector
   function automatic logic [15:0] pic_vector(input logic [4:0] idx);
      logic [15:0] v;
      v = VEC_SOFT;
      if (idx == IDX_TRAP)
         v = VEC_TRAP;
      else if (idx == IDX_WDT)
         v = VEC_WDT;
      else if (idx >= IDX_MASKABLE && idx < IDX_SPLIT)
         v = VEC_LOW_BASE - {10'h0, idx - IDX_MASKABLE, 1'b0};
      else if (idx >= IDX_SPLIT)
         v = VEC_HIGH_BASE - {10'h0, idx - IDX_SPLIT, 1'b0};
      return v;
   endfunction : pic_vector
   // true for every mapped register index
   function automatic logic pic_reg_hit(input logic [7:0] idx);
      return idx == IDX_EN_HIGH || idx == IDX_IL_HIGH ||
         idx == IDX_CTRL || idx == IDX_STAT || idx == IDX_EN_LOW ||
         idx == IDX_EN_MID || idx == IDX_IL_LOW || idx == IDX_IL_MID;
   endfunction : pic_reg_hit
endpackage : pic_pkg

/* File: hw/pic_latch_bank.sv */
// bank of pending latches, set taking priority over clear
`timescale 1ns/100ps
`default_nettype none
module pic_latch_bank
   import pic_pkg::*;
(
   input wire logic core_clk, // core clock
   input wire logic nrst, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic [23:0] set_mask, // source requests
   input wire logic [23:0] clr_mask, // software and acceptance clears
   output logic [23:0] latch // pending latch state
);
   logic [NUM_SRC-1:FIRST_LATCH] store; // real latches only
   // the two shared-vector sources own no latch
   assign latch = {store, 2'h0};
   genvar i;
   generate
      for (i = FIRST_LATCH; i < NUM_SRC; i++) begin : g_bit
         // one latch; a request in the clear cycle survives
         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               store[i] <= 1'b0;
            end else if (ce) begin
               store[i] <= set_mask[i] | (store[i] & ~clr_mask[i]);
            end
         end
      end
   endgenerate
endmodule : pic_latch_bank
`default_nettype wire

/* File: hw/pic_prio.sv */
// fixed priority picker: the lowest eligible index wins
`timescale 1ns/100ps
`default_nettype none
module pic_prio
   import pic_pkg::*;
(
   input wire logic [23:0] cand, // eligible requests by index
   output pic_win_type win // winning index
);
   // scan downward so the lowest index is written last
   always_comb begin
      win = '{valid: 1'b0, idx: 5'h0};
      for (int k = NUM_SRC - 1; k >= 0; k--) begin
         if (cand[k]) begin
            win.valid = 1'b1;
            win.idx = 5'(k);
         end
      end
   end
endmodule : pic_prio
`default_nettype wire

/* File: hw/pic_ctrl.sv */
// top of the prioritized interrupt controller with its apb registers
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
module pic_ctrl
   import pic_pkg::*;
(
   input wire logic core_clk, // core clock, 200 MHz
   input wire logic nrst, // async reset, active low
   input wire logic ce, // clock enable, freezes all state
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, high writes
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [23:4] src_req, // maskable source pulses
   input wire logic trap_event, // address trap detected
   input wire logic wdt_event, // watchdog expired
   input wire logic software_irq, // software interrupt request
   input wire logic illegal_opcode_irq, // undefined instruction
   input wire logic instr_done, // current instruction completes
   input wire logic enable_instruction, // sets master enable
   input wire logic disable_instruction, // clears master enable
   input wire logic maskable_return, // return from maskable
   input wire logic nonmaskable_return, // return from fixed
   input wire logic ret_imf, // master enable popped from stack
   output logic irq_pending, // an eligible request waits
   output logic accept_start, // acceptance begins
   output logic seq_busy, // acceptance sequence running
   output logic push_strobe, // cpu pushes one stack byte
   output logic [1:0] push_sel, // 1 status, 2 pc high, 3 pc low
   output logic stack_imf, // master enable to stack
   output logic vector_load, // load vector into pc
   output logic [15:0] vector, // entry vector address
   output logic reset_request // trap or watchdog chose reset
);
   //////////////////////////////////////////////////////////////////
   // state
   logic global_irq_enable; // global_irq_enable
   logic [23:4] ef; // source_enable_flag bits
   logic [2:0] ctrl; // watchdog_control_one selects, pin enable
   logic [23:0] il; // pending_latch bank
   pic_state_type state; // acceptance sequencer
   logic [3:0] cnt; // acceptance step counter
   logic [4:0] acc_idx; // index being accepted
   pic_win_type win; // current priority winner
   logic next_imf; // master enable next value
   logic [23:4] next_ef; // enables next value
   logic [2:0] next_ctrl; // control next value
   pic_state_type next_state; // sequencer next state
   //////////////////////////////////////////////////////////////////
   // apb decode
   wire logic [7:0] idx = paddr[9:2]; // register index
   wire logic setup = psel & ~penable; // setup phase
   wire logic mapped = pic_reg_hit(idx) && paddr[1:0] == 2'h0 &&
      paddr[11:10] == 2'h0; // legal register address
   wire logic wr_go = psel & penable & pready & pwrite & mapped;
   wire logic wr_enl = wr_go && idx == IDX_EN_LOW;
   wire logic wr_enm = wr_go && idx == IDX_EN_MID;
   wire logic wr_enh = wr_go && idx == IDX_EN_HIGH;
   wire logic wr_ill = wr_go && idx == IDX_IL_LOW;
   wire logic wr_ilm = wr_go && idx == IDX_IL_MID;
   wire logic wr_ilh = wr_go && idx == IDX_IL_HIGH;
   wire logic wr_ctl = wr_go && idx == IDX_CTRL; // select writes
   wire logic [7:0] wb = pwdata[7:0]; // written byte
   //////////////////////////////////////////////////////////////////
   // read mux; reserved bits read zero
   wire logic [7:0] rd_byte =
      (idx == IDX_EN_LOW) ? {ef[7:4], 3'h0, global_irq_enable} :
      (idx == IDX_EN_MID) ? ef[15:8] :
      (idx == IDX_EN_HIGH) ? ef[23:16] :
      (idx == IDX_IL_LOW) ? il[7:0] :
      (idx == IDX_IL_MID) ? il[15:8] :
      (idx == IDX_IL_HIGH) ? il[23:16] :
      (idx == IDX_CTRL) ? {5'h0, ctrl} :
      (idx == IDX_STAT) ? {seq_busy, irq_pending, 1'b0, win.idx} :
      8'h0;
   //////////////////////////////////////////////////////////////////
   // latch set and clear masks
   // trap and watchdog latch only when their select picks interrupt
   wire logic trap_set = trap_event & ~ctrl[TRAP_SEL_BIT];
   wire logic wdt_set = wdt_event & ~ctrl[WDT_SEL_BIT];
   // only sources set latches; no write path reaches set
   wire logic [23:0] set_mask = {src_req, wdt_set, trap_set, 2'h0};
   // written zeros clear, ones leave the latch alone
   wire logic [23:0] sw_clr = {wr_ilh ? ~wb : 8'h0,
      wr_ilm ? ~wb : 8'h0, wr_ill ? ~wb : 8'h0};
   // acceptance start
   wire logic go = state == ST_IDLE && instr_done && win.valid;
   // only the captured winner is cleared, others stay pending
   wire logic [23:0] acc_clr = (go && win.idx >= IDX_TRAP) ?
      (24'h1 << win.idx) : 24'h0;
   //////////////////////////////////////////////////////////////////
   // eligibility and priority
   // fixed sources: shared soft request at 0, trap 2, watchdog 3
   wire logic [3:0] nmi_vec = {il[3], il[2], 1'b0,
      software_irq | illegal_opcode_irq};
   // maskable gate: master, own flag, pin enable for source 0
   wire logic [23:4] mask_ok = global_irq_enable ?
      (ef & {19'h7ffff, ctrl[PIN0_EN_BIT]}) : 20'h0;
   // fixed sources sit below index 4, so they always outrank
   wire logic [23:0] cand = {il[23:4] & mask_ok, nmi_vec};
   //////////////////////////////////////////////////////////////////
   // latch bank
   pic_latch_bank u_latch (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .set_mask(set_mask),
      .clr_mask(sw_clr | acc_clr),
      .latch(il)
   );
   // lowest eligible index wins
   pic_prio u_prio (
      .cand(cand),
      .win(win)
   );
   //////////////////////////////////////////////////////////////////
   // next values of the software registers
   // acceptance clears master enable before anything else
   assign next_imf = go ? 1'b0 :
      (maskable_return | nonmaskable_return) ? ret_imf :
      enable_instruction ? 1'b1 :
      disable_instruction ? 1'b0 :
      wr_enl ? wb[IMF_BIT] : global_irq_enable;
   assign next_ef = {wr_enh ? wb : ef[23:16],
      wr_enm ? wb : ef[15:8], wr_enl ? wb[7:4] : ef[7:4]};
   assign next_ctrl = wr_ctl ? wb[2:0] : ctrl;
   // software registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         global_irq_enable <= IMF_RESET;
         ef <= EF_RESET;
         ctrl <= CTRL_RESET;
      end else if (ce) begin
         global_irq_enable <= next_imf;
         ef <= next_ef;
         ctrl <= next_ctrl;
      end
   end
   //////////////////////////////////////////////////////////////////
   // apb answer: ready in the first access cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (ce) begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= {24'h0, rd_byte};
         end
      end
   end
   //////////////////////////////////////////////////////////////////
   // sequencer next state
   always_comb begin
      case (state)
         ST_IDLE: begin
            // wait for an instruction boundary with a winner
            next_state = go ? ST_PUSH : ST_IDLE;
         end
         ST_PUSH: begin
            // stack pushes, then wait out the machine cycles
            next_state = (cnt == ACCEPT_CLKS - 4'h1) ? ST_LOAD : ST_PUSH;
         end
         ST_LOAD: begin
            // vector goes to the pc, sequence ends
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end
   // sequencer state and step count
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         acc_idx <= 5'h0;
      end else if (ce) begin
         state <= next_state;
         cnt <= go ? 4'h1 : cnt + 4'h1;
         if (go) begin
            acc_idx <= win.idx;
         end
      end
   end
   //////////////////////////////////////////////////////////////////
   // cpu-facing strobes
   wire logic in_push = state == ST_PUSH; // sequence running
   wire logic push_now = in_push && cnt <= LAST_PUSH;
   wire logic load_now = in_push && cnt == ACCEPT_CLKS - 4'h1;
   // registered cpu outputs
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         accept_start <= 1'b0;
         seq_busy <= 1'b0;
         push_strobe <= 1'b0;
         push_sel <= 2'h0;
         stack_imf <= 1'b0;
         irq_pending <= 1'b0;
      end else if (ce) begin
         accept_start <= go;
         seq_busy <= go | in_push;
         push_strobe <= push_now;
         push_sel <= push_now ? cnt[1:0] : 2'h0;
         irq_pending <= win.valid;
         if (go) begin
            stack_imf <= global_irq_enable;
         end
      end
   end
   // vector load and reset choice
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         vector_load <= 1'b0;
         vector <= 16'h0;
         reset_request <= 1'b0;
      end else if (ce) begin
         vector_load <= load_now;
         if (load_now) begin
            vector <= pic_vector(acc_idx);
         end
         reset_request <= (trap_event & ctrl[TRAP_SEL_BIT]) |
            (wdt_event & ctrl[WDT_SEL_BIT]);
      end
   end
   //////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   chk_latch_set: assert property (
      (ce && set_mask != 24'h0) |=>
         ((il & $past(set_mask)) == $past(set_mask)))
      else $error("request did not set its latch");
   chk_no_sw_set: assert property (
      (ce && set_mask == 24'h0) |=> ((il & ~$past(il)) == 24'h0))
      else $error("latch set without a request");
   chk_lowest_wins: assert property (
      go |-> (cand & ((24'h1 << win.idx) - 24'h1)) == 24'h0)
      else $error("lower index request was passed over");
   chk_fixed_first: assert property (
      (go && nmi_vec != 4'h0) |-> win.idx < IDX_MASKABLE)
      else $error("maskable beat a fixed source");
   chk_master_gate: assert property (
      (go && !global_irq_enable) |-> win.idx < IDX_MASKABLE)
      else $error("maskable accepted with master off");
   chk_pin_gate: assert property (
      (go && win.idx == IDX_MASKABLE) |-> ctrl[PIN0_EN_BIT] && ef[4])
      else $error("source 0 accepted while gated");
   chk_latch_clear: assert property (
      (ce && go && win.idx >= IDX_TRAP && !set_mask[win.idx]) |=>
         !il[acc_idx])
      else $error("accepted latch still set");
   chk_accept_entry: assert property (
      (ce && go) |=> !global_irq_enable && stack_imf == $past(global_irq_enable) && accept_start)
      else $error("master enable not cleared and stacked");
   chk_accept_len: assert property (
      (ce && go) |=> seq_busy [*7] ##1 (seq_busy && (vector_load || !ce)))
      else $error("acceptance not eight cycles long");
   chk_vector_value: assert property (
      vector_load |-> vector == pic_vector(acc_idx))
      else $error("wrong vector loaded");
   chk_trap_reset: assert property (
      (ce && trap_event && ctrl[TRAP_SEL_BIT]) |=> reset_request)
      else $error("trap did not request reset");
   chk_wdt_latch: assert property (
      (ce && wdt_event && !ctrl[WDT_SEL_BIT]) |=> il[3] && !reset_request)
      else $error("watchdog interrupt not latched");
endmodule : pic_ctrl
`default_nettype wire

/* File: sim/pic_cpu_model.sv */
// cpu core stand-in: instruction boundaries, software request, push check
`timescale 1ns/100ps
`default_nettype none
module pic_cpu_model
   import pic_pkg::*;
(
   input wire logic core_clk, // core clock
   input wire logic nrst, // async reset, active low
   input wire logic run, // let instructions complete
   input wire logic swi_cmd, // raise the software request
   input wire logic accept_start, // acceptance begins
   input wire logic seq_busy, // acceptance running
   input wire logic push_strobe, // one stack byte pushed
   input wire logic [1:0] push_sel, // kind of pushed byte
   input wire logic vector_load, // vector goes to pc
   input wire logic [15:0] vector, // entry vector
   output logic instr_done, // instruction boundary pulse
   output logic software_irq, // held until accepted
   output logic [15:0] vec_seen, // last vector loaded
   output logic [3:0] acc_len, // cycles from start to load
   output logic [3:0] push_err // pushes out of order
);
   logic [1:0] next_sel; // push kind expected next
   logic [1:0] pushes; // stack pushes in this acceptance
   //////////////////////////////////////////////////////////////////////
   // a boundary every other cycle keeps acceptance points irregular
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         instr_done <= 1'b0;
         software_irq <= 1'b0;
         vec_seen <= 16'h0000;
         acc_len <= 4'h0;
         push_err <= 4'h0;
         next_sel <= 2'h1;
         pushes <= 2'h0;
      end else begin
         instr_done <= run & ~instr_done;
         // no latch here: the core holds it until taken
         if (accept_start)
            software_irq <= 1'b0;
         else if (swi_cmd)
            software_irq <= 1'b1;
         // counts cycles 1..8 of the sequence
         if (accept_start)
            acc_len <= 4'h1;
         else if (seq_busy)
            acc_len <= acc_len + 4'h1;
         // status, pc high, pc low, in that order
         if (push_strobe) begin
            next_sel <= (next_sel == 2'h3) ? 2'h1 : next_sel + 2'h1;
            if (push_sel != next_sel)
               push_err <= push_err + 4'h1;
         end
         // exactly three pushes before the vector is loaded
         if (accept_start)
            pushes <= 2'h0;
         else if (push_strobe)
            pushes <= pushes + 2'h1;
         if (vector_load && pushes != 2'h3)
            push_err <= push_err + 4'h1;
         if (vector_load)
            vec_seen <= vector;
      end
   end
endmodule : pic_cpu_model
`default_nettype wire

/* File: sim/prioritized_interrupt_controller_tb.sv */
// self-checking bench of the interrupt controller and its cpu stand-in
`timescale 1ns/100ps
`default_nettype none
module prioritized_interrupt_controller_tb;
   logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, trap_event = 1'b0, wdt_event = 1'b0;
   logic swi_cmd = 1'b0, run = 1'b0, illegal_opcode_irq = 1'b0;
   logic enable_instruction = 1'b0, disable_instruction = 1'b0;
   logic maskable_return = 1'b0, nonmaskable_return = 1'b0;
   logic ret_imf = 1'b0, ce = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [23:4] src_req = 20'h00000;
   logic [31:0] prdata;
   logic pready, pslverr, irq_pending, accept_start, seq_busy;
   logic push_strobe, stack_imf, vector_load, reset_request;
   logic instr_done, software_irq, e;
   logic [1:0] push_sel;
   logic [15:0] vector, vec_seen, v;
   logic [3:0] acc_len, push_err;
   logic [7:0] q, m;
   logic [4:0] i;
   logic [20:0] rows [24]; // source index beside its vector
   int failures = 0, cmp_count = 0;
   always #2.5 core_clk = ~core_clk;
   pic_ctrl uut (.core_clk, .nrst, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .src_req, .trap_event,
      .wdt_event, .software_irq, .illegal_opcode_irq, .instr_done,
      .enable_instruction, .disable_instruction, .maskable_return,
      .nonmaskable_return, .ret_imf, .irq_pending, .accept_start,
      .seq_busy, .push_strobe, .push_sel, .stack_imf, .vector_load,
      .vector, .reset_request);
   pic_cpu_model cpu (.core_clk, .nrst, .run, .swi_cmd, .accept_start,
      .seq_busy, .push_strobe, .push_sel, .vector_load, .vector,
      .instr_done, .software_irq, .vec_seen, .acc_len, .push_err);
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: saw %h, wanted %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   // one apb transfer, held until pready is seen at an edge
   task automatic bus(input logic w, input logic [7:0] idx,
         input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   // enable group (lat=0) or latch group (lat=1) word of a source
   function automatic logic [7:0] reg_of(input logic [4:0] s, input logic lat);
      return s < 5'd8 ? (lat ? 8'h3c : 8'h3a) :
         s < 5'd16 ? (lat ? 8'h3d : 8'h3b) : (lat ? 8'h2e : 8'h2c);
   endfunction : reg_of
   function automatic logic [15:0] exp_vec(input logic [4:0] s);
      return s < 5'd2 ? 16'hfffc : s == 5'd2 ? 16'hfffa :
         s == 5'd3 ? 16'hfff8 : s < 5'd16 ? 16'hfff6 - 16'(2 * (s - 5'd4)) :
         16'hffbe - 16'(2 * (s - 5'd16));
   endfunction : exp_vec
   // request of a source, one cycle except illegal opcode, which take clears; 0 software, 1 illegal opcode
   task automatic raise(input logic [4:0] s);
      swi_cmd <= (s == 5'd0);
      trap_event <= (s == 5'd2);
      wdt_event <= (s == 5'd3);
      if (s == 5'd1)
         illegal_opcode_irq <= 1'b1;
      if (s >= 5'd4)
         src_req[s] <= 1'b1;
      @(posedge core_clk);
      {swi_cmd, trap_event, wdt_event} <= 3'b000;
      src_req <= 20'h00000;
   endtask : raise
   task automatic ins(input logic on);
      enable_instruction <= on;
      disable_instruction <= ~on;
      @(posedge core_clk);
      {enable_instruction, disable_instruction} <= 2'b00;
   endtask : ins
   task automatic ret(input logic nm);
      nonmaskable_return <= nm;
      maskable_return <= ~nm;
      ret_imf <= 1'b1;
      @(posedge core_clk);
      {nonmaskable_return, maskable_return, ret_imf} <= 3'b000;
   endtask : ret
   // run the core until one acceptance has finished
   task automatic take(input logic [15:0] vx, input logic global_irq_enable);
      run <= 1'b1;
      while (accept_start !== 1'b1)
         @(posedge core_clk);
      chk(16'(stack_imf), 16'(global_irq_enable));
      illegal_opcode_irq <= 1'b0;
      while (vector_load !== 1'b1)
         @(posedge core_clk);
      run <= 1'b0;
      @(posedge core_clk);
      chk(vec_seen, vx);
      chk(16'(acc_len), 16'h0008);
   endtask : take
   //////////////////////////////////////////////////////////////////////
   initial begin
      for (int k = 0; k < 24; k++)
         rows[k] = {5'(k), exp_vec(5'(k))};
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      bus(1'b0, 8'h3a, 8'h00);
      chk(16'(q), 16'h0000);
      bus(1'b0, 8'h30, 8'h00);
      chk(16'(q), 16'h0003);
      bus(1'b0, 8'h3c, 8'h00);
      chk(16'(q), 16'h0000);
      bus(1'b0, 8'h01, 8'h00);
      chk(16'(e), 16'h0001);
      // selects at one turn trap and watchdog into reset requests
      for (int k = 2; k < 4; k++) begin
         raise(5'(k));
         @(posedge core_clk);
         chk(16'(reset_request), 16'h0001);
         bus(1'b0, 8'h3c, 8'h00);
         chk(16'(q), 16'h0000);
      end
      bus(1'b1, 8'h3c, 8'hff);
      bus(1'b0, 8'h3c, 8'h00);
      chk(16'(q), 16'h0000);
      bus(1'b1, 8'h30, 8'h04);
      // every source alone, from the table
      for (int k = 0; k < 24; k++) begin
         {i, v} = rows[k];
         m = 8'h01 << i[2:0];
         if (i >= 5'd4) begin
            bus(1'b1, reg_of(i, 1'b0), m);
            ins(1'b1);
         end
         raise(i);
         if (i >= 5'd2) begin
            @(posedge core_clk);
            bus(1'b0, reg_of(i, 1'b1), 8'h00);
            chk(16'(q & m), 16'(m));
         end
         take(v, i >= 5'd4);
         if (i >= 5'd2) begin
            bus(1'b0, reg_of(i, 1'b1), 8'h00);
            chk(16'(q & m), 16'h0000);
         end
         if (i >= 5'd4) begin
            bus(1'b0, 8'h3a, 8'h00);
            chk(16'(q[0]), 16'h0000);
            bus(1'b1, reg_of(i, 1'b0), 8'h00);
         end
      end
      // a fixed and two maskable requests in the same cycle
      bus(1'b1, 8'h3a, 8'h21);
      bus(1'b1, 8'h3b, 8'h02);
      {src_req[5], src_req[9], trap_event} <= 3'b111;
      @(posedge core_clk);
      {src_req[5], src_req[9], trap_event} <= 3'b000;
      take(16'hfffa, 1'b1);
      ret(1'b1);
      take(16'hfff4, 1'b1);
      ret(1'b0);
      take(16'hffec, 1'b1);
      // pin enable of the first external source gates it
      bus(1'b1, 8'h30, 8'h00);
      bus(1'b1, 8'h3a, 8'h11);
      raise(5'd4);
      repeat (2) @(posedge core_clk);
      chk(16'(irq_pending), 16'h0000);
      bus(1'b1, 8'h30, 8'h04);
      repeat (2) @(posedge core_clk);
      chk(16'(irq_pending), 16'h0001);
      // status: pending flag and winner index 4
      bus(1'b0, 8'h31, 8'h00);
      chk(16'(q), 16'h0044);
      ins(1'b0);
      repeat (2) @(posedge core_clk);
      chk(16'(irq_pending), 16'h0000);
      // a request landing on the clearing write survives it
      fork
         bus(1'b1, 8'h3c, 8'h0c);
         begin
            @(posedge core_clk);
            src_req[4] <= 1'b1;
            @(posedge core_clk);
            src_req <= 20'h00000;
         end
      join
      bus(1'b0, 8'h3c, 8'h00);
      chk(16'(q), 16'h0010);
      bus(1'b1, 8'h3c, 8'h0c);
      bus(1'b0, 8'h3c, 8'h00);
      chk(16'(q), 16'h0000);
      // clock enable low: a request in that cycle is not taken
      ce <= 1'b0;
      raise(5'd6);
      ce <= 1'b1;
      bus(1'b0, 8'h3c, 8'h00);
      chk(16'(q), 16'h0000);
      chk(16'(push_err), 16'h0000);
      test_done();
   end
   // cut a hang short
   initial begin
      #100000;
      failures++;
      test_done();
   end
endmodule : prioritized_interrupt_controller_tb
`default_nettype wire
